// ===== rtl/sdbs_map.vh
`ifndef SDBS_MAP_VH
`define SDBS_MAP_VH
// =====================================================
// Command encodings {ras_n, cas_n, we_n}
`define SDBS_CMD_NOP    3'h7
`define SDBS_CMD_ACT    3'h3
`define SDBS_CMD_RD     3'h5
`define SDBS_CMD_WR     3'h4
`define SDBS_CMD_BST    3'h6
`define SDBS_CMD_PRE    3'h2
`define SDBS_CMD_REF    3'h1
`define SDBS_CMD_MODE   3'h0
// =====================================================
// Mode word fields
`define SDBS_MODE_BL_LSB 0
`define SDBS_MODE_BL_MSB 2
`define SDBS_MODE_CL_LSB 4
`define SDBS_MODE_CL_MSB 6
`define SDBS_MODE_WBS    9
`define SDBS_MODE_RST    12'h000
// Auto precharge address bit
`define SDBS_AP_BIT      10
// =====================================================
// Timing, ns, and counts at 10 ns clock
`define SDBS_CLK_NS      10
`define SDBS_TRP_NS      20
`define SDBS_TRCD_NS     20
`define SDBS_TWR_NS      15
`define SDBS_TRFC_NS     66
`define SDBS_TMRD_CYC    2
`define SDBS_TXSR_NS     75
`define SDBS_TRP_CYC  ((`SDBS_TRP_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_TRCD_CYC ((`SDBS_TRCD_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_TWR_CYC  ((`SDBS_TWR_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_TRFC_CYC ((`SDBS_TRFC_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`define SDBS_TXSR_CYC ((`SDBS_TXSR_NS + `SDBS_CLK_NS - 1) / `SDBS_CLK_NS)
`endif

// ===== rtl/sdbs_core.v
// Function
// - Burst terminate hits only the running burst
// - Interrupted auto precharge burst starts precharge
// - Read cut by read after CAS latency
// - Write cuts plain read at registration
// - Read cuts plain write at registration
// - Write cuts plain write at registration
// - Auto precharge read cut by read, precharge now
// - Auto precharge read cut by write, precharge now
// - Auto precharge write cut by read, tWR first
// - Auto precharge write cut by write, tWR first
// - Power-down on CKE low with all banks idle, exits next edge
// - Self refresh via refresh, tXSR exit wait
// - CKE low mid-burst freezes, resumes next edge
// - Outputs off after mode load, tMRD wait
// - Chip select high means no operation
`timescale 1ns/1ps
`include "sdbs_map.vh"
module sdbs_core (
  input  wire        i_ref_clk,    // Device clock
  input  wire        i_rst,        // Async model reset
  input  wire        i_cke,        // Clock enable
  input  wire        i_cs_n,       // Chip select, low active
  input  wire        i_ras_n,      // Row strobe, low active
  input  wire        i_cas_n,      // Column strobe, low active
  input  wire        i_we_n,       // Write enable, low active
  input  wire [1:0]  i_ba,         // Bank address
  input  wire [11:0] i_addr,       // Address / mode word
  input  wire        i_dqm,        // Data mask
  output reg  [3:0]  o_bank_busy,  // Bank not idle
  output reg  [3:0]  o_bank_open,  // Row open per bank
  output reg         o_rd_act,     // Read burst running
  output reg         o_wr_act,     // Write burst accepting data
  output reg  [1:0]  o_burst_bank, // Bank of running burst
  output reg         o_dq_oe,      // Data output enable
  output reg         o_wr_take,    // Write data accepted this edge
  output reg         o_power_down, // In power-down
  output reg         o_self_ref,   // In self refresh
  output reg         o_suspend,    // In clock suspend
  output reg         o_dev_busy,   // Refresh / mode / exit wait
  output reg  [11:0] o_mode        // Mode register
);
  // =====================================================
  // One-hot device states
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_PDN = 4'h2;
  localparam [3:0] ST_SRF = 4'h4;
  localparam [3:0] ST_SUS = 4'h8;

  reg  [3:0] state;              // Device state
  reg        cke_q;              // CKE at previous edge
  reg  [7:0] dev_cnt;            // Refresh / mode / exit wait
  reg  [3:0] bank_cnt [0:3];     // Per bank precharge / activate wait
  reg  [3:0] ap_pend;            // Auto precharge armed
  reg  [3:0] wr_cnt [0:3];       // tWR wait before precharge
  reg  [3:0] rd_left;            // Read beats left
  reg  [3:0] wr_left;            // Write beats left
  reg  [3:0] rd_lat;             // Cycles to read data
  reg  [3:0] cut_cnt;            // Delayed read cut
  reg  [1:0] rd_bank;            // Bank of read burst
  reg        rd_ap;              // Read burst has auto precharge
  wire [3:0] busy_now;           // Bank not idle at this edge

  // =====================================================
  // Timing loads as integers; counters take the low bits
  // on purpose, every count fits its counter
  localparam integer TRP_I  = `SDBS_TRP_CYC;       // Precharge wait
  localparam integer TRCD_I = `SDBS_TRCD_CYC;      // Activate wait
  localparam integer TWR_I  = `SDBS_TWR_CYC;       // Write recovery
  localparam integer TRFC_I = `SDBS_TRFC_CYC - 1;  // Refresh wait
  localparam integer TMRD_I = `SDBS_TMRD_CYC - 1;  // Mode load wait
  localparam integer TXSR_I = `SDBS_TXSR_CYC;      // Self refresh exit

  // =====================================================
  // Decode helpers
  function is_cmd;
    input [2:0] c;
    input [2:0] ref_c;
    begin
      is_cmd = (c == ref_c);
    end
  endfunction

  function [3:0] bl_len;
    input [2:0] code;
    begin
      case (code)
        3'h0:    bl_len = 4'h1;
        3'h1:    bl_len = 4'h2;
        3'h2:    bl_len = 4'h4;
        3'h3:    bl_len = 4'h8;
        default: bl_len = 4'hf;  // Continuous: held until cut
      endcase
    end
  endfunction

  // Chip select high masks every command
  wire [2:0] cmd = i_cs_n ? `SDBS_CMD_NOP :
                   {i_ras_n, i_cas_n, i_we_n};
  wire       live   = (state == ST_RUN) && i_cke;
  // Live counters, not the registered flags: a refresh right
  // after tRP must not be refused by a one-cycle-old view
  wire       all_idle = ~|busy_now & ~o_dev_busy;
  wire       ap     = i_addr[`SDBS_AP_BIT];
  wire [3:0] cl     = {1'b0, o_mode[`SDBS_MODE_CL_MSB:`SDBS_MODE_CL_LSB]};
  wire [3:0] blen   = bl_len(o_mode[`SDBS_MODE_BL_MSB:`SDBS_MODE_BL_LSB]);
  wire       do_rd  = live && is_cmd(cmd, `SDBS_CMD_RD);
  wire       do_wr  = live && is_cmd(cmd, `SDBS_CMD_WR);
  wire       do_ref = live && is_cmd(cmd, `SDBS_CMD_REF) && all_idle;
  wire       do_mode = live && is_cmd(cmd, `SDBS_CMD_MODE)
                       && all_idle && (i_ba == 2'h0);
  wire       do_bst = live && is_cmd(cmd, `SDBS_CMD_BST);
  wire       do_pre = live && is_cmd(cmd, `SDBS_CMD_PRE);
  wire       burst  = o_rd_act | o_wr_act;

  // =====================================================
  // CKE state machine: power-down, self refresh, suspend
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RUN;
      cke_q <= 1'b1;
    end else begin
      cke_q <= i_cke;
      case (state)
        ST_RUN: begin
          if (cke_q && !i_cke) begin
            if (burst)
              state <= ST_SUS;
            else if (all_idle && is_cmd(cmd, `SDBS_CMD_REF))
              state <= ST_SRF;
            else if (all_idle && is_cmd(cmd, `SDBS_CMD_NOP))
              state <= ST_PDN;
          end
        end
        ST_PDN: if (i_cke && is_cmd(cmd, `SDBS_CMD_NOP)) begin
          state <= ST_RUN;
        end
        ST_SRF: if (i_cke && is_cmd(cmd, `SDBS_CMD_NOP)) begin
          state <= ST_RUN;
        end
        ST_SUS: if (i_cke) begin
          state <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // =====================================================
  // Device wide wait: refresh, mode load, self refresh exit
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dev_cnt <= 8'h00;
      o_mode  <= `SDBS_MODE_RST;
    end else if (state == ST_SRF && i_cke &&
                 is_cmd(cmd, `SDBS_CMD_NOP)) begin
      dev_cnt <= TXSR_I[7:0];
    end else if (do_ref && state == ST_RUN && i_cke) begin
      dev_cnt <= TRFC_I[7:0];
    end else if (do_mode) begin
      o_mode  <= i_addr;
      dev_cnt <= TMRD_I[7:0];
    end else if (dev_cnt != 8'h00 && state != ST_SRF) begin
      dev_cnt <= dev_cnt - 8'h01;
    end
  end

  // =====================================================
  // Burst engine: reads, writes and cross-bank cuts
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_left <= 4'h0;
      wr_left <= 4'h0;
      rd_lat  <= 4'h0;
      cut_cnt <= 4'h0;
      rd_bank <= 2'h0;
      rd_ap   <= 1'b0;
      o_wr_take <= 1'b0;
      o_burst_bank <= 2'h0;
    end else if (state == ST_SUS || !i_cke) begin
      o_wr_take <= 1'b0;
    end else begin
      o_wr_take <= o_wr_act && !i_dqm && !do_rd && !do_wr;
      if (do_rd) begin
        // A read: a running read ends CL later, a write ends now
        if (o_rd_act)
          cut_cnt <= cl;
        wr_left <= 4'h0;
        rd_lat  <= cl;
        rd_bank <= i_ba;
        rd_ap   <= ap;
        o_burst_bank <= i_ba;
      end else if (do_wr) begin
        rd_left <= 4'h0;
        rd_lat  <= 4'h0;
        cut_cnt <= 4'h0;
        wr_left <= o_mode[`SDBS_MODE_WBS] ? 4'h1 : blen;
        o_burst_bank <= i_ba;
      end else if (do_pre && (ap || i_ba == o_burst_bank)) begin
        // Precharge of the burst bank truncates its burst
        rd_left <= 4'h0;
        wr_left <= 4'h0;
        rd_lat  <= 4'h0;
        cut_cnt <= 4'h0;
      end else if (do_bst) begin
        rd_left <= 4'h0;
        wr_left <= 4'h0;
      end else begin
        if (wr_left != 4'h0 && wr_left != 4'hf)
          wr_left <= wr_left - 4'h1;
        // Old read keeps streaming while the new one waits
        if (rd_left != 4'h0 && rd_left != 4'hf)
          rd_left <= rd_left - 4'h1;
        if (rd_lat > 4'h1)
          rd_lat <= rd_lat - 4'h1;
        else if (rd_lat == 4'h1) begin
          rd_lat  <= 4'h0;
          rd_left <= blen;
        end
        // Cut only where no new burst takes over that edge
        if (cut_cnt == 4'h1 && rd_lat != 4'h1)
          rd_left <= 4'h0;
        if (cut_cnt != 4'h0)
          cut_cnt <= cut_cnt - 4'h1;
      end
    end
  end

  // =====================================================
  // Burst flags and data output enable
  always @* begin
    o_rd_act = (rd_left != 4'h0) || (rd_lat != 4'h0);
    o_wr_act = (wr_left != 4'h0);
    o_dq_oe  = (rd_left != 4'h0) && !o_dev_busy;
    o_suspend    = (state == ST_SUS);
    o_power_down = (state == ST_PDN);
    o_self_ref   = (state == ST_SRF);
    o_dev_busy   = (dev_cnt != 8'h00) || (state == ST_SRF);
  end

  // =====================================================
  // Per bank state: activate, precharge, concurrent auto precharge
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_bank
      // Bank number as an integer so its low bits can be taken
      localparam integer BI = b;
      wire hit  = (i_ba == BI[1:0]);
      wire pre  = live && is_cmd(cmd, `SDBS_CMD_PRE) && (hit || ap);
      wire act  = live && is_cmd(cmd, `SDBS_CMD_ACT) && hit;
      wire cut  = (do_rd || do_wr) && !hit && ap_pend[b];
      wire wr_b = o_wr_act && (o_burst_bank == BI[1:0]);
      // Live idle view used by refresh and mode checks
      assign busy_now[b] = o_bank_open[b] || (bank_cnt[b] != 4'h0)
                           || ap_pend[b] || (wr_cnt[b] != 4'h0);
      always @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          bank_cnt[b]    <= 4'h0;
          wr_cnt[b]      <= 4'h0;
          ap_pend[b]     <= 1'b0;
          o_bank_open[b] <= 1'b0;
          o_bank_busy[b] <= 1'b0;
        end else begin
          // Registered view, one cycle behind the live one
          o_bank_busy[b] <= busy_now[b];
          if (act) begin
            o_bank_open[b] <= 1'b1;
            bank_cnt[b]    <= TRCD_I[3:0];
          end else if (pre) begin
            o_bank_open[b] <= 1'b0;
            bank_cnt[b]    <= TRP_I[3:0];
          end else if ((do_rd || do_wr) && hit) begin
            ap_pend[b] <= ap;
          end else if (cut && wr_b) begin
            ap_pend[b] <= 1'b0;
            wr_cnt[b]  <= TWR_I[3:0];
          end else if (cut) begin
            ap_pend[b]     <= 1'b0;
            o_bank_open[b] <= 1'b0;
            bank_cnt[b]    <= TRP_I[3:0];
          end else if (wr_cnt[b] == 4'h1) begin
            // Write recovery met: precharge starts now
            wr_cnt[b]      <= 4'h0;
            o_bank_open[b] <= 1'b0;
            bank_cnt[b]    <= TRP_I[3:0];
          end else begin
            if (wr_cnt[b] != 4'h0)
              wr_cnt[b] <= wr_cnt[b] - 4'h1;
            if (bank_cnt[b] != 4'h0)
              bank_cnt[b] <= bank_cnt[b] - 4'h1;
            if (ap_pend[b] && !burst) begin
              ap_pend[b]     <= 1'b0;
              o_bank_open[b] <= 1'b0;
              bank_cnt[b]    <= TRP_I[3:0];
            end
          end
        end
      end
    end
  endgenerate
endmodule // sdbs_core

// ===== dv/sdbs_core_properties.sv
`timescale 1ns/1ps
`include "sdbs_map.vh"
// ==============================
// Port checks of the command core
module sdbs_core_properties (
  input wire        i_ref_clk,
  input wire        i_rst,
  input wire        i_cke,
  input wire        i_cs_n,
  input wire        i_ras_n,
  input wire        i_cas_n,
  input wire        i_we_n,
  input wire [11:0] i_addr,
  input wire [3:0]  o_bank_busy,
  input wire        o_rd_act,
  input wire        o_wr_act,
  input wire        o_dq_oe,
  input wire        o_power_down,
  input wire        o_self_ref,
  input wire        o_suspend,
  input wire        o_dev_busy,
  input wire [11:0] o_mode
);
  // Command decode as the core accepts it
  wire [2:0] cmd  = {i_ras_n, i_cas_n, i_we_n};
  wire       run  = !o_power_down && !o_self_ref && !o_suspend;
  wire       take = run && i_cke && !i_cs_n && !o_dev_busy;
  wire       idle = run && !o_dev_busy && !o_rd_act && !o_wr_act
    && o_bank_busy == 4'h0;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_deselect_nop: assert property (i_cs_n |=> $stable(o_mode))
    else $error("mode moved while deselected");
  a_mode_load: assert property (take && cmd == `SDBS_CMD_MODE && idle
    |=> o_mode == $past(i_addr)) else $error("mode word not loaded");
  a_mode_hiz: assert property ($changed(o_mode) |-> !o_dq_oe)
    else $error("outputs on at mode load");
  a_pd_entry: assert property (!i_cke && $past(i_cke) && i_cs_n
    && idle |=> o_power_down) else $error("no power-down entry");
  a_pd_exit: assert property (o_power_down && i_cke
    |=> !o_power_down && !o_dev_busy) else $error("slow power-down exit");
  a_sr_exit: assert property (o_self_ref && i_cke
    |=> o_dev_busy [*2] ##[1:12] !o_dev_busy) else $error("bad exit wait");
  a_susp_exit: assert property (o_suspend && i_cke |=> !o_suspend)
    else $error("suspend held after enable");
  a_wr_cut_rd: assert property (take && cmd == `SDBS_CMD_WR && o_rd_act
    |=> !o_rd_act && o_wr_act) else $error("read not cut by write");
  a_rd_cut_wr: assert property (take && cmd == `SDBS_CMD_RD && o_wr_act
    |=> !o_wr_act) else $error("write not cut by read");
  c_power_down: cover property (o_power_down);
  c_self_ref: cover property (o_self_ref);
  c_suspend: cover property (o_suspend);
endmodule // sdbs_core_properties
bind sdbs_core sdbs_core_properties chk (.*);

// ===== dv/sdbs_ctl_model.sv
`timescale 1ns/1ps
`include "sdbs_map.vh"
// ==============================
// Controller side of the command bus
module sdbs_ctl_model #(
  parameter INIT_WAIT = 10000 // Power-up wait in cycles
) (
  input  wire        i_ref_clk,
  output reg         o_cke,
  output reg         o_cs_n,
  output reg  [2:0]  o_cmd,
  output reg  [1:0]  o_ba,
  output reg  [11:0] o_addr,
  output reg         o_dqm
);
  // Enable low and bus deselected at power-up
  initial begin
    {o_cke, o_cs_n, o_cmd, o_ba, o_addr, o_dqm} = {5'h0f, 15'h0000};
  end
  // Command held for the next rising edge
  task send(input cs, input [2:0] c, input [1:0] b, input [11:0] a);
    begin
      {o_cs_n, o_cmd, o_ba, o_addr} = {cs, c, b, a};
      @(negedge i_ref_clk);
    end
  endtask
  // Deselect; address flipped so no stale value lingers
  task nop(input integer n);
    begin
      {o_cs_n, o_cmd, o_addr} = {1'b1, 3'h7, ~o_addr};
      repeat (n) @(negedge i_ref_clk);
    end
  endtask
  // Clock enable and data mask
  task pins(input k, input m);
    begin
      {o_cke, o_dqm} = {k, m};
    end
  endtask
  // Power-up: wait, precharge all, two refreshes, mode load
  task init(input [11:0] word);
    begin
      nop(INIT_WAIT / 2);
      pins(1'b1, 1'b0);
      nop(INIT_WAIT / 2);
      send(1'b0, `SDBS_CMD_PRE, 2'h0, 12'h400);
      nop(`SDBS_TRP_CYC);
      repeat (2) begin
        send(1'b0, `SDBS_CMD_REF, 2'h0, 12'h000);
        nop(`SDBS_TRFC_CYC);
      end
      send(1'b0, `SDBS_CMD_MODE, 2'h0, word);
      nop(`SDBS_TMRD_CYC);
    end
  endtask
endmodule // sdbs_ctl_model

// ===== dv/sdram_bank_cke_init_sequencing_tb.sv
`timescale 1ns/1ps
`include "sdbs_map.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %h got %h", n, e, a); end end
module sdram_bank_cke_init_sequencing_tb;
  reg         clk;
  reg         rst;
  wire        cke;
  wire        cs_n;
  wire [2:0]  cmd;
  wire [1:0]  ba;
  wire [11:0] addr;
  wire        dqm;
  wire [3:0]  bank_busy;
  wire [3:0]  bank_open;
  wire        rd_act;
  wire        wr_act;
  wire [1:0]  burst_bank;
  wire        dq_oe;
  wire        wr_take;
  wire        power_down;
  wire        self_ref;
  wire        suspend;
  wire        dev_busy;
  wire [11:0] mode;
  integer     miscompares = 0;
  integer     samples_checked = 0;
  integer     i;
  sdbs_ctl_model #(.INIT_WAIT(10000)) ctl (.i_ref_clk(clk), .o_cke(cke),
    .o_cs_n(cs_n), .o_cmd(cmd), .o_ba(ba), .o_addr(addr), .o_dqm(dqm));
  sdbs_core dut (.i_ref_clk(clk), .i_rst(rst), .i_cke(cke), .i_cs_n(cs_n),
    .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba),
    .i_addr(addr), .i_dqm(dqm), .o_bank_busy(bank_busy),
    .o_bank_open(bank_open), .o_rd_act(rd_act), .o_wr_act(wr_act),
    .o_burst_bank(burst_bank), .o_dq_oe(dq_oe), .o_wr_take(wr_take),
    .o_power_down(power_down), .o_self_ref(self_ref), .o_suspend(suspend),
    .o_dev_busy(dev_busy), .o_mode(mode));
  // ==============================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    complete_run;
  end
  // Two rows opened, then tRCD
  task open2(input [1:0] a, input [1:0] b);
    begin
      ctl.send(1'b0, `SDBS_CMD_ACT, a, 12'h000);
      ctl.send(1'b0, `SDBS_CMD_ACT, b, 12'h000);
      ctl.nop(2);
    end
  endtask
  // Precharge all and let tRP pass
  task pall;
    begin
      ctl.send(1'b0, `SDBS_CMD_PRE, 2'h0, 12'h400);
      ctl.nop(4);
    end
  endtask
  task t_init;
    begin
      ctl.init(12'h027);
      `CHK("mode", 12'h027, mode)
      `CHK("busy", 4'h0, bank_busy)
      ctl.send(1'b1, `SDBS_CMD_MODE, 2'h0, 12'h031);
      ctl.nop(1);
      `CHK("mode deselected", 12'h027, mode)
      $display("init test done");
    end
  endtask
  task t_cross;
    begin
      open2(2'h0, 2'h1);
      ctl.send(1'b0, `SDBS_CMD_RD, 2'h0, 12'h000);
      ctl.nop(2);
      ctl.send(1'b0, `SDBS_CMD_RD, 2'h1, 12'h000);
      ctl.nop(0);
      for (i = 0; i < 4; i++) begin
        `CHK("dq_oe", 1'b1, dq_oe)
        @(negedge clk);
      end
      `CHK("burst bank", 2'h1, burst_bank)
      ctl.pins(1'b1, 1'b1);
      ctl.nop(1);
      ctl.pins(1'b1, 1'b0);
      ctl.send(1'b0, `SDBS_CMD_WR, 2'h0, 12'h000);
      `CHK("read cut", 2'h1, {rd_act, wr_act})
      ctl.send(1'b0, `SDBS_CMD_RD, 2'h1, 12'h000);
      `CHK("write cut", 1'b0, wr_act)
      ctl.send(1'b0, `SDBS_CMD_WR, 2'h0, 12'h000);
      ctl.send(1'b0, `SDBS_CMD_WR, 2'h1, 12'h000);
      `CHK("write bank", 3'h5, {wr_act, burst_bank})
      ctl.nop(1);
      `CHK("write beat", 1'b1, wr_take)
      pall;
      $display("cross bank test done");
    end
  endtask
  task t_ap;
    begin
      open2(2'h2, 2'h3);
      ctl.send(1'b0, `SDBS_CMD_WR, 2'h2, 12'h400);
      ctl.send(1'b0, `SDBS_CMD_RD, 2'h3, 12'h000);
      ctl.nop(1);
      `CHK("twr hold", 1'b1, bank_busy[2])
      ctl.nop(8);
      `CHK("ap idle", 2'h0, {bank_busy[2], bank_open[2]})
      pall;
      $display("auto precharge test done");
    end
  endtask
  task t_cke;
    begin
      ctl.pins(1'b0, 1'b0);
      ctl.nop(2);
      `CHK("power down", 1'b1, power_down)
      ctl.pins(1'b1, 1'b0);
      ctl.nop(1);
      `CHK("pd exit", 1'b0, power_down)
      ctl.pins(1'b0, 1'b0);
      ctl.send(1'b0, `SDBS_CMD_REF, 2'h0, 12'h000);
      ctl.nop(2);
      `CHK("self refresh", 1'b1, self_ref)
      ctl.pins(1'b1, 1'b0);
      ctl.nop(2);
      `CHK("exit wait", 2'h1, {self_ref, dev_busy})
      ctl.nop(12);
      `CHK("exit done", 1'b0, dev_busy)
      open2(2'h0, 2'h1);
      ctl.send(1'b0, `SDBS_CMD_RD, 2'h0, 12'h000);
      ctl.nop(2);
      ctl.pins(1'b0, 1'b0);
      ctl.nop(2);
      `CHK("suspend", 1'b1, suspend)
      ctl.pins(1'b1, 1'b0);
      ctl.nop(1);
      `CHK("resume", 2'h1, {suspend, rd_act})
      pall;
      $display("clock enable test done");
    end
  endtask
  // Verdict and end of run
  task complete_run;
    begin
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_init;
    t_cross;
    t_ap;
    t_cke;
    complete_run;
  end
endmodule // sdram_bank_cke_init_sequencing_tb
